/* File: shared/sarc_pkg.sv */
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: APB byte addresses, 8-bit registers in the low byte of each word
// Notes:   Result bytes carry no reset value
package sarc_pkg;

  // ==========================================================
  // Register map
  localparam int          APB_AW   = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_REF  = 8'h04;
  localparam logic [7:0]  OFS_FMT  = 8'h08;
  localparam logic [7:0]  OFS_RESH = 8'h0C;
  localparam logic [7:0]  OFS_RESL = 8'h10;
  localparam logic [7:0]  OFS_STAT = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_GO_BIT  = 1;
  localparam int CTRL_CHS_LSB = 2;
  localparam int REF_PCFG_LSB = 0;
  localparam int REF_VCFG_LSB = 4;
  localparam int FMT_CS_LSB   = 0;
  localparam int FMT_JUST_BIT = 7;
  localparam int STAT_DONE_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REF_RST  = 8'h00;
  localparam logic [7:0] FMT_RST  = 8'h00;

  // ==========================================================
  // Conversion clock codes and divider terminal counts
  localparam logic [2:0] CS_DIV2  = 3'h0;
  localparam logic [2:0] CS_DIV8  = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV4  = 3'h4;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;
  localparam logic [5:0] LAST_DIV2  = 6'h01;
  localparam logic [5:0] LAST_DIV4  = 6'h03;
  localparam logic [5:0] LAST_DIV8  = 6'h07;
  localparam logic [5:0] LAST_DIV16 = 6'h0F;
  localparam logic [5:0] LAST_DIV32 = 6'h1F;
  localparam logic [5:0] LAST_DIV64 = 6'h3F;

  // ==========================================================
  // Timing in bit periods
  localparam int         RES_BITS      = 10;
  localparam logic [3:0] CONV_LAST_TAD = 4'hB;
  localparam logic [3:0] BIT_FIRST_TAD = 4'h1;
  localparam logic [3:0] BIT_LAST_TAD  = 4'hA;
  localparam logic [1:0] WAIT_LAST_TAD = 2'h1;
  localparam logic [9:0] MASK_MSB      = 10'h200;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } sarc_state_t;

  typedef struct packed {
    logic [3:0]  chan;
    logic        chanValid;
    logic [1:0]  refSel;
    logic [15:0] pinAnalog;
    logic        sampleEn;
    logic [9:0]  dacCode;
  } sarc_afe_t;

  typedef struct packed {
    logic [3:0] chan;
    logic       go;
    logic       en;
  } sarc_ctrl_t;

endpackage

/* File: rtl/sarc_tad_gen.sv */
// Purpose: Bit period enable generator for the SAR converter
// Assumes: Internal RC clock arrives as a one-cycle tick on clk
// Notes:   Oscillator divide stops in sleep, RC ticks continue
`timescale 1ns/1ns
module sarc_tad_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] clkSel,
  input  wire logic       sleepMode,
  input  wire logic       rcTick,
  // Bit period enable
  output logic            tadTick
);

  // ==========================================================
  // Divider
  function automatic logic [5:0] lastCount(input logic [2:0] sel);
    case (sel)
      sarc_pkg::CS_DIV2:  lastCount = sarc_pkg::LAST_DIV2;
      sarc_pkg::CS_DIV4:  lastCount = sarc_pkg::LAST_DIV4;
      sarc_pkg::CS_DIV8:  lastCount = sarc_pkg::LAST_DIV8;
      sarc_pkg::CS_DIV16: lastCount = sarc_pkg::LAST_DIV16;
      sarc_pkg::CS_DIV32: lastCount = sarc_pkg::LAST_DIV32;
      sarc_pkg::CS_DIV64: lastCount = sarc_pkg::LAST_DIV64;
      default:            lastCount = sarc_pkg::LAST_DIV2;
    endcase
  endfunction

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic       useRc;
  logic       wrap;

  always_comb begin
    useRc = (clkSel[1:0] == sarc_pkg::CS_RC_LOW);
    wrap  = (cnt_reg == lastCount(clkSel));
    if (!run || useRc || sleepMode) begin
      cnt_next = 6'h00;
    end else if (wrap) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
    tadTick = run && (useRc ? rcTick : (!sleepMode && wrap));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

/* File: rtl/sarc_core.sv */
// Purpose: Control of a 10-bit successive approximation converter
// Assumes: APB slave with no wait states, comparator answers within a bit period
// Notes:   Functional notes below
// Functional notes
// - Twelve or sixteen channels, 10-bit results
// - Four-bit channel select, upper four optional
// - Go flag starts conversion, clears when done
// - Enable bit switches converter on
// - Two-bit reference source selection
// - Port code sets analog pin range
// - Justify bit selects result alignment
// - Clock select divides oscillator or picks RC
// - Conversions continue in sleep on RC
// - Successive approximation, one bit per period
// - Reset clears registers except result pair, aborts conversion
// - Completion loads result, clears go, sets done
// - Result pair untouched by reset
// - Two bit periods before next acquisition
// - Unimplemented bits read zero
// - Conversion lasts twelve bit periods
// - Clearing go aborts, result kept
// - After abort wait, acquisition restarts
// - Compare trigger starts only when enabled
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
module sarc_core #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Device side events
  input  wire logic               sleepMode,
  input  wire logic               rcTick,
  input  wire logic               cmpTrigger,
  // Analog front end
  input  wire logic               compAbove,
  output sarc_pkg::sarc_afe_t     afe
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] pinMask(input logic [3:0] code);
    logic [15:0] m;
    m = 16'h0000;
    if (code == 4'h0) begin
      m = 16'hFFFF;
    end else if (code != 4'hF) begin
      m = (16'h0001 << (5'h0F - {1'b0, code})) - 16'h0001;
    end
    if (!LARGE_VARIANT) begin
      m[15:12] = 4'h0;
    end
    pinMask = m;
  endfunction

  function automatic logic [15:0] justify(input logic right, input logic [9:0] r);
    if (right) begin
      justify = {6'h00, r};
    end else begin
      justify = {r, 6'h00};
    end
  endfunction

  function automatic logic hit(input logic [7:0] a);
    hit = (a == sarc_pkg::OFS_CTRL) || (a == sarc_pkg::OFS_REF) || (a == sarc_pkg::OFS_FMT) ||
          (a == sarc_pkg::OFS_RESH) || (a == sarc_pkg::OFS_RESL) || (a == sarc_pkg::OFS_STAT);
  endfunction

  // ==========================================================
  // State
  sarc_pkg::sarc_ctrl_t  ctrl_reg,  ctrl_next;
  logic [7:0]            ref_reg,   ref_next;
  logic [7:0]            fmt_reg,   fmt_next;
  logic [7:0]            resH_reg,  resH_next;
  logic [7:0]            resL_reg,  resL_next;
  logic                  done_reg,  done_next;
  sarc_pkg::sarc_state_t state_reg, state_next;
  logic [3:0]            tadCnt_reg, tadCnt_next;
  logic [1:0]            waitCnt_reg, waitCnt_next;
  logic [9:0]            sar_reg,   sar_next;
  logic [9:0]            mask_reg,  mask_next;
  sarc_pkg::sarc_afe_t   afe_reg,   afe_next;
  logic [31:0]           rd_reg,    rd_next;
  logic                  wrEn;
  logic                  ctrlWr;
  logic                  swAbort;
  logic                  complete;
  logic                  goSet;
  logic                  goClr;
  logic                  tadTick;
  logic [15:0]           resWord;

  // ==========================================================
  // Bit period generator
  sarc_tad_gen sarc_tad_gen_i (
    .clk       (clk),
    .reset     (reset),
    .run       (state_reg != sarc_pkg::ST_IDLE),
    .clkSel    (fmt_reg[sarc_pkg::FMT_CS_LSB +: 3]),
    .sleepMode (sleepMode),
    .rcTick    (rcTick),
    .tadTick   (tadTick)
  );

  // ==========================================================
  // APB access
  always_comb begin
    pready  = 1'b1;
    pslverr = psel && penable && !hit(paddr);
    prdata  = rd_reg;
    wrEn    = psel && penable && pwrite && hit(paddr);
    ctrlWr  = wrEn && (paddr == sarc_pkg::OFS_CTRL);
    rd_next = rd_reg;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        sarc_pkg::OFS_CTRL: rd_next = {26'h000_0000, ctrl_reg};
        sarc_pkg::OFS_REF:  rd_next = {26'h000_0000, ref_reg[5:0]};
        sarc_pkg::OFS_FMT:  rd_next = {24'h00_0000, fmt_reg[7], 4'h0, fmt_reg[2:0]};
        sarc_pkg::OFS_RESH: rd_next = {24'h00_0000, resH_reg};
        sarc_pkg::OFS_RESL: rd_next = {24'h00_0000, resL_reg};
        sarc_pkg::OFS_STAT: rd_next = {29'h0000_0000, state_reg == sarc_pkg::ST_WAIT,
                                       state_reg == sarc_pkg::ST_CONV, done_reg};
        default:            rd_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    swAbort  = (state_reg == sarc_pkg::ST_CONV) && ctrlWr &&
               (!pwdata[sarc_pkg::CTRL_GO_BIT] || !pwdata[sarc_pkg::CTRL_EN_BIT]);
    complete = (state_reg == sarc_pkg::ST_CONV) && !swAbort && tadTick &&
               (tadCnt_reg == sarc_pkg::CONV_LAST_TAD);
    state_next   = state_reg;
    tadCnt_next  = tadCnt_reg;
    waitCnt_next = waitCnt_reg;
    sar_next     = sar_reg;
    mask_next    = mask_reg;
    case (state_reg)
      sarc_pkg::ST_IDLE: begin
        if (ctrl_reg.go && ctrl_reg.en) begin
          state_next  = sarc_pkg::ST_CONV;
          tadCnt_next = 4'h0;
          sar_next    = 10'h000;
          mask_next   = sarc_pkg::MASK_MSB;
        end
      end
      sarc_pkg::ST_CONV: begin
        if (swAbort || complete) begin
          state_next   = sarc_pkg::ST_WAIT;
          waitCnt_next = 2'h0;
        end else if (tadTick) begin
          tadCnt_next = tadCnt_reg + 4'h1;
          if (tadCnt_reg >= sarc_pkg::BIT_FIRST_TAD && tadCnt_reg <= sarc_pkg::BIT_LAST_TAD) begin
            sar_next  = compAbove ? (sar_reg | mask_reg) : sar_reg;
            mask_next = mask_reg >> 1;
          end
        end
      end
      sarc_pkg::ST_WAIT: begin
        if (tadTick) begin
          if (waitCnt_reg == sarc_pkg::WAIT_LAST_TAD) begin
            state_next = sarc_pkg::ST_IDLE;
          end else begin
            waitCnt_next = waitCnt_reg + 2'h1;
          end
        end
      end
      default: begin
        state_next = sarc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers and flags
  always_comb begin
    ctrl_next = ctrl_reg;
    ref_next  = ref_reg;
    fmt_next  = fmt_reg;
    resH_next = resH_reg;
    resL_next = resL_reg;
    resWord   = justify(fmt_reg[sarc_pkg::FMT_JUST_BIT], sar_reg);
    if (ctrlWr) begin
      ctrl_next.en   = pwdata[sarc_pkg::CTRL_EN_BIT];
      ctrl_next.chan = pwdata[sarc_pkg::CTRL_CHS_LSB +: 4];
    end
    goSet = (ctrlWr && pwdata[sarc_pkg::CTRL_GO_BIT] && ctrl_reg.en) ||
            (cmpTrigger && ctrl_reg.en);
    goClr = complete || (ctrlWr && !pwdata[sarc_pkg::CTRL_GO_BIT]);
    ctrl_next.go = (goSet || (ctrl_reg.go && !goClr)) && ctrl_next.en;
    if (wrEn && paddr == sarc_pkg::OFS_REF) begin
      ref_next = {2'h0, pwdata[5:0]};
    end
    if (wrEn && paddr == sarc_pkg::OFS_FMT) begin
      fmt_next = {pwdata[7], 4'h0, pwdata[2:0]};
    end
    if (complete) begin
      resH_next = resWord[15:8];
      resL_next = resWord[7:0];
    end else begin
      if (wrEn && paddr == sarc_pkg::OFS_RESH) begin
        resH_next = pwdata[7:0];
      end
      if (wrEn && paddr == sarc_pkg::OFS_RESL) begin
        resL_next = pwdata[7:0];
      end
    end
    done_next = complete ||
                (done_reg && !(wrEn && paddr == sarc_pkg::OFS_STAT && pwdata[sarc_pkg::STAT_DONE_BIT]));
    afe_next.chan      = ctrl_next.chan;
    afe_next.chanValid = LARGE_VARIANT || !ctrl_next.chan[3] || !ctrl_next.chan[2];
    afe_next.refSel    = ref_next[sarc_pkg::REF_VCFG_LSB +: 2];
    afe_next.pinAnalog = pinMask(ref_next[sarc_pkg::REF_PCFG_LSB +: 4]);
    afe_next.sampleEn  = (state_next == sarc_pkg::ST_IDLE) && ctrl_next.en;
    afe_next.dacCode   = (state_next == sarc_pkg::ST_CONV) ? (sar_next | mask_next) : 10'h000;
    afe = afe_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg    <= sarc_pkg::sarc_ctrl_t'(sarc_pkg::CTRL_RST[5:0]);
      ref_reg     <= sarc_pkg::REF_RST;
      fmt_reg     <= sarc_pkg::FMT_RST;
      done_reg    <= 1'b0;
      state_reg   <= sarc_pkg::ST_IDLE;
      tadCnt_reg  <= 4'h0;
      waitCnt_reg <= 2'h0;
      sar_reg     <= 10'h000;
      mask_reg    <= 10'h000;
      afe_reg     <= '{chan: sarc_pkg::CTRL_RST[5:2], chanValid: 1'b1, refSel: sarc_pkg::REF_RST[5:4],
                       pinAnalog: pinMask(sarc_pkg::REF_RST[3:0]), sampleEn: 1'b0, dacCode: 10'h000};
      rd_reg      <= 32'h0000_0000;
    end else begin
      ctrl_reg    <= ctrl_next;
      ref_reg     <= ref_next;
      fmt_reg     <= fmt_next;
      done_reg    <= done_next;
      state_reg   <= state_next;
      tadCnt_reg  <= tadCnt_next;
      waitCnt_reg <= waitCnt_next;
      sar_reg     <= sar_next;
      mask_reg    <= mask_next;
      afe_reg     <= afe_next;
      rd_reg      <= rd_next;
    end
  end

  // Result pair has no reset
  always_ff @(posedge clk) begin
    resH_reg <= resH_next;
    resL_reg <= resL_next;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [3:0] ticks_reg;
  always_ff @(posedge clk) begin
    if (reset || state_reg != sarc_pkg::ST_CONV) begin
      ticks_reg <= 4'h0;
    end else if (tadTick) begin
      ticks_reg <= ticks_reg + 4'h1;
    end
  end

  sequence s_convStart;
    state_reg == sarc_pkg::ST_IDLE ##1 state_reg == sarc_pkg::ST_CONV;
  endsequence

  sequence s_waitDone;
    state_reg == sarc_pkg::ST_WAIT ##1 state_reg == sarc_pkg::ST_IDLE;
  endsequence

  a_done_event: assert property (complete |=> done_reg && !ctrl_reg.go &&
      state_reg == sarc_pkg::ST_WAIT) else $error("completion did not set done and clear go");
  a_result_load: assert property (complete |=> {resH_reg, resL_reg} ==
      justify($past(fmt_reg[7]), $past(sar_reg))) else $error("result not loaded");
  a_twelve_tads: assert property (complete |-> ticks_reg == 4'hB && tadCnt_reg == ticks_reg)
      else $error("conversion length wrong");
  a_two_tad_wait: assert property (s_waitDone |-> $past(tadTick) && $past(waitCnt_reg) == 2'h1)
      else $error("wait shorter than two periods");
  a_abort_keeps: assert property (swAbort |=> $stable({resH_reg, resL_reg}) && !done_reg ||
      $past(done_reg)) else $error("abort disturbed result");
  a_conv_start: assert property (s_convStart |-> $past(ctrl_reg.go) && $past(ctrl_reg.en) &&
      mask_reg == sarc_pkg::MASK_MSB && sar_reg == 10'h000) else $error("bad start");
  a_bit_shift: assert property (state_reg == sarc_pkg::ST_CONV && tadTick && !swAbort &&
      tadCnt_reg == 4'h1 |=> mask_reg == 10'h100) else $error("bit not resolved");
  a_trig_ignored: assert property (cmpTrigger && !ctrl_reg.en && !ctrlWr |=> !ctrl_reg.go)
      else $error("trigger accepted while off");
  a_trig_start: assert property (cmpTrigger && ctrl_reg.en && !ctrlWr |=> ctrl_reg.go)
      else $error("trigger lost");
  a_pin_map: assert property (afe.pinAnalog == pinMask(ref_reg[3:0]))
      else $error("pin map mismatch");
  a_reset_off: assert property ($past(reset) |-> state_reg == sarc_pkg::ST_IDLE && !ctrl_reg.en)
      else $error("reset left converter on");
  a_sleep_halt: assert property (sleepMode && fmt_reg[1:0] != sarc_pkg::CS_RC_LOW |-> !tadTick)
      else $error("oscillator tick in sleep");
  a_reserved_zero: assert property (psel && !penable && !pwrite && paddr == sarc_pkg::OFS_FMT
      |=> prdata[6:3] == 4'h0) else $error("reserved bits nonzero");

endmodule

/* File: tb/sarc_afe_model.sv */
// Purpose: Behavioural sample-and-hold and comparator for the converter
// Assumes: Held level taken on the last tracking edge
// Notes:   Output is noise while tracking
`timescale 1ns/1ns
module sarc_afe_model (
  // Clock
  input  wire logic                clk,
  // Front end controls and analog level
  input  wire sarc_pkg::sarc_afe_t afe,
  input  wire logic [9:0]          vin,
  // Comparator
  output logic                     compAbove
);
  // ==========================================================
  // Hold and compare
  logic [9:0] heldReg;
  logic       noiseReg = 1'b0;

  always @(posedge clk) begin
    noiseReg <= ~noiseReg;
    if (afe.sampleEn) begin
      heldReg <= vin;
    end
  end

  assign compAbove = afe.sampleEn ? noiseReg : (heldReg >= afe.dacCode);
endmodule

/* File: tb/sarc_adc_control_test.sv */
// Purpose: Self-checking bench for the SAR converter control block
// Assumes: Zero wait APB, comparator model on the far side
// Notes:   Reads are checked by a monitor against a queue
`timescale 1ns/1ns
module sar_adc_control_test;
  // ==========================================================
  // Signals
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                sleepMode = 1'b0;
  logic                rcTick = 1'b0;
  logic                cmpTrigger = 1'b0;
  logic                compAbove;
  logic [9:0]          vin = 10'h000;
  sarc_pkg::sarc_afe_t afe;
  logic [32:0]         expQ[$];
  string               nameQ[$];
  int                  num_errors = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  int                  busyCyc = 0;
  int                  n;
  logic [7:0]          resHi;
  logic [7:0]          resLo;
  logic [2:0]          csTab[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int                  perTab[8] = '{2, 4, 8, 16, 32, 64, 5, 5};

  // ==========================================================
  // Design and front end
  sarc_core sarc_core_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepMode(sleepMode), .rcTick(rcTick), .cmpTrigger(cmpTrigger),
    .compAbove(compAbove), .afe(afe)
  );
  sarc_afe_model sarc_afe_model_i (.clk(clk), .afe(afe), .vin(vin), .compAbove(compAbove));

  always #5 clk = ~clk;

  // ==========================================================
  // Timeout, RC ticks, busy counter, read monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rcTick <= (cyc % 5 == 0);
    if (afe.dacCode != 10'h000) begin
      busyCyc <= busyCyc + 1;
    end
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      chk(nameQ.pop_front(), expQ.pop_front(), {pslverr, prdata});
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count = check_count + 1;
    if (e !== g) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors = num_errors + 1;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e,
                      input string nm);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    if (!w) begin
      expQ.push_back(e);
      nameQ.push_back(nm);
    end
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 33'h0_0000_0000, "");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    xfer(1'b0, a, 8'h00, {25'h000_0000, e}, nm);
  endtask

  task automatic waitIdle();
    do @(posedge clk); while (afe.sampleEn !== 1'b1);
  endtask

  function automatic logic [15:0] pinExp(input int k);
    if (k == 0) return 16'hFFFF;
    return (16'h0001 << (15 - k)) - 16'h0001;
  endfunction

  task automatic conv(input logic [2:0] cs, input int p, input logic [3:0] ch);
    logic       just;
    logic [9:0] v;
    just = 1'($urandom % 2);
    v = 10'(1 + $urandom % 1023);
    vin <= v;
    resHi = just ? {6'h00, v[9:8]} : v[9:2];
    resLo = just ? v[7:0] : {v[1:0], 6'h00};
    wr(sarc_pkg::OFS_FMT, {just, 4'h0, cs});
    wr(sarc_pkg::OFS_CTRL, {2'h0, ch, 2'h1});
    repeat (20) @(posedge clk);
    busyCyc = 0;
    wr(sarc_pkg::OFS_CTRL, {2'h0, ch, 2'h3});
    do @(posedge clk); while (afe.sampleEn === 1'b1);
    waitIdle();
    chk("convLength", 33'h1, {32'h0, busyCyc > 11 * p && busyCyc <= 12 * p});
    rd(sarc_pkg::OFS_RESH, resHi, "resultHigh");
    rd(sarc_pkg::OFS_RESL, resLo, "resultLow");
    rd(sarc_pkg::OFS_CTRL, {2'h0, ch, 2'h1}, "goCleared");
    rd(sarc_pkg::OFS_STAT, 8'h01, "doneSet");
    wr(sarc_pkg::OFS_STAT, 8'h01);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h4f78));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(sarc_pkg::OFS_CTRL, 8'h00, "ctrlReset");
    rd(sarc_pkg::OFS_REF, 8'h00, "refReset");
    rd(sarc_pkg::OFS_FMT, 8'h00, "fmtReset");
    xfer(1'b0, 8'h18, 8'h00, 33'h1_0000_0000, "unmapped");
    wr(sarc_pkg::OFS_CTRL, 8'hFF);
    wr(sarc_pkg::OFS_REF, 8'hFF);
    wr(sarc_pkg::OFS_FMT, 8'hFF);
    rd(sarc_pkg::OFS_CTRL, 8'h3D, "ctrlBits");
    rd(sarc_pkg::OFS_REF, 8'h3F, "refBits");
    rd(sarc_pkg::OFS_FMT, 8'h87, "fmtBits");
    for (int k = 0; k < 16; k++) begin
      wr(sarc_pkg::OFS_REF, {2'h0, 2'(k), 4'(k)});
      wr(sarc_pkg::OFS_CTRL, {2'h0, 4'(k), 2'h1});
      @(posedge clk);
      chk("afeRouting", {10'h000, 4'(k), 1'b1, 2'(k), pinExp(k)},
          {10'h000, afe.chan, afe.chanValid, afe.refSel, afe.pinAnalog});
    end
    wr(sarc_pkg::OFS_REF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      sleepMode <= (i == 7);
      conv(csTab[i], perTab[i], 4'(i));
    end
    sleepMode <= 1'b1;
    wr(sarc_pkg::OFS_FMT, 8'h00);
    wr(sarc_pkg::OFS_CTRL, 8'h03);
    repeat (100) @(posedge clk);
    rd(sarc_pkg::OFS_CTRL, 8'h03, "sleepStall");
    rd(sarc_pkg::OFS_STAT, 8'h02, "busyStat");
    sleepMode <= 1'b0;
    repeat (6) @(posedge clk);
    wr(sarc_pkg::OFS_CTRL, 8'h01);
    for (n = 0; n < 20 && afe.sampleEn !== 1'b1; n++) @(posedge clk);
    chk("abortRestart", 33'h1, {32'h0, afe.sampleEn === 1'b1});
    rd(sarc_pkg::OFS_RESH, resHi, "abortHigh");
    rd(sarc_pkg::OFS_RESL, resLo, "abortLow");
    rd(sarc_pkg::OFS_STAT, 8'h00, "abortNoDone");
    wr(sarc_pkg::OFS_CTRL, 8'h00);
    cmpTrigger <= 1'b1;
    @(posedge clk);
    cmpTrigger <= 1'b0;
    @(posedge clk);
    rd(sarc_pkg::OFS_CTRL, 8'h00, "trigDisabled");
    wr(sarc_pkg::OFS_CTRL, 8'h01);
    repeat (20) @(posedge clk);
    cmpTrigger <= 1'b1;
    @(posedge clk);
    cmpTrigger <= 1'b0;
    rd(sarc_pkg::OFS_CTRL, 8'h03, "trigEnabled");
    repeat (2) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(sarc_pkg::OFS_CTRL, 8'h00, "ctrlMidReset");
    rd(sarc_pkg::OFS_RESH, resHi, "resHighKept");
    rd(sarc_pkg::OFS_RESL, resLo, "resLowKept");
    stop_test();
  end
endmodule
